// ==== system_config_status_regs.vh ====
// Register offsets, field positions, reset values and timing counts
`ifndef SYSTEM_CONFIG_STATUS_REGS_VH
`define SYSTEM_CONFIG_STATUS_REGS_VH
`define VERSION_CODE_HI_ADDR 16'h0002
`define VERSION_CODE_LO_ADDR 16'h0003
`define SYSTEM_STATUS_ADDR 16'h2000
`define SOFT_RESET_CONTROL_ADDR 16'h2004
`define IRQ_AND_CLOCK_CONFIG_ADDR 16'h2005
`define TICK_COUNTER_HI_ADDR 16'h2016
`define TICK_COUNTER_LO_ADDR 16'h2017
`define TICK_COUNTER_CLEAR_ADDR 16'h2020
`define CHIP_LOCK_BIT 7
`define NETWORK_LOCK_BIT 6
`define PHY_LOCK_BIT 5
`define PARALLEL_MODE_BIT 1
`define SPI_MODE_BIT 0
`define SOFT_RESET_BIT 7
`define IRQ_ENABLE_BIT 7
`define SYSCLK_SELECT_BIT 0
`define SOFT_RESET_CONTROL_RESET 8'h80
`define IRQ_AND_CLOCK_CONFIG_RESET 8'h80
`define TICK_COUNTER_RESET 16'h0000
`define VERSION_CODE_VALUE 16'h1234 // Arbitrary value
`define TICK_CYCLES 16'h07d0 // 100 us of 50 ns clock cycles
`endif

// ==== tick_timer.v ====
// Free-running 100 us tick counter with clear
`timescale 1ns/1ps
`include "system_config_status_regs.vh"
module tick_timer #(
  parameter [15:0] TICK_CYCLES = `TICK_CYCLES
) (
  input wire core_clk,
  input wire resetn,
  input wire clear,
  output reg [15:0] tickCount
);
  reg [15:0] prescale_reg;
  always @(posedge core_clk)
  begin
    if (!resetn || clear)
    begin
      prescale_reg <= 16'h0000; // RQ15
      tickCount <= `TICK_COUNTER_RESET; // RQ15
    end
    else if (prescale_reg == TICK_CYCLES - 16'h0001)
    begin
      prescale_reg <= 16'h0000;
      tickCount <= tickCount + 16'h0001; // RQ14
    end
    else
    begin
      prescale_reg <= prescale_reg + 16'h0001;
    end
  end
endmodule // tick_timer

// ==== system_config_status_regs.v ====
// Common system register bank: version, status, soft reset, config, tick counter
// Summary of operation
// [RQ1] Fixed 16-bit version code, high byte at the lower address.
// [RQ2] Read-only status byte shows lock states and host interface mode.
// [RQ3] Bit 7 shows chip lock; when set, both config registers refuse writes.
// [RQ4] Bit 6 shows network lock; when set, network address writes are refused.
// [RQ5] Network lock covers MAC, IPv4 and IPv6 addresses and IPv6 prefix.
// [RQ6] IPv6 gateway address stays writable regardless of network lock.
// [RQ7] Bit 5 shows PHY lock; when set, PHY control writes are refused.
// [RQ8] Bit 1 is 1 when mode pins read 010X, parallel bus host mode.
// [RQ9] Bit 0 is 1 for SPI mode pins; bits 4 to 2 read zero.
// [RQ10] Writing 0 to soft-reset bit 7 reinitialises all registers; resets to 0x80.
// [RQ11] Soft-reset register accepts writes only while chip lock is 0.
// [RQ12] Config bit 7 gates active-low interrupt; 0 keeps pin high.
// [RQ13] Config bit 0 selects 100MHz or 25MHz clock, only while unlocked.
// [RQ14] Read-only 16-bit tick counter, reset zero, increments every 100us.
// [RQ15] Any write to tick clear register zeroes the tick counter.
// [RQ16] Refused writes are silently ignored; stored value stays unchanged.
`timescale 1ns/1ps
`include "system_config_status_regs.vh"
module system_config_status_regs (
  input wire core_clk,
  input wire resetn,
  input wire [15:0] regAddr,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regWriteData,
  output reg [7:0] regReadData,
  input wire chipLockFlag,
  input wire networkLockFlag,
  input wire phyLockFlag,
  input wire [3:0] modePins,
  input wire eventPending,
  input wire netAddrWriteReq,
  input wire ipv6GatewayWriteReq,
  input wire phyCtrlWriteReq,
  output wire netAddrWriteEn,
  output wire ipv6GatewayWriteEn,
  output wire phyCtrlWriteEn,
  output reg irqOutN,
  output wire sysclkSelect,
  output reg softResetN
);
  wire [7:0] syncIn;
  wire [7:0] syncOut;
  wire [3:0] modeSync;
  wire chipLock;
  wire networkLock;
  wire phyLock;
  wire eventSync;
  wire parallelHostModeFlag;
  wire spiHostModeFlag;
  wire [7:0] systemStatus;
  wire [15:0] tickCounter;
  wire [15:0] versionCode;
  wire softResetRequest;
  wire softResetWrite;
  wire configWrite;
  wire tickClear;
  wire localResetN;
  reg [7:0] softReset_reg;
  reg [7:0] softReset_next;
  reg [7:0] config_reg;
  reg [7:0] config_next;
  reg [7:0] readData_next;
  reg irqOut_next;
  genvar bitIndex;

  // Version code, read as two bytes, high byte first
  assign versionCode = `VERSION_CODE_VALUE; // Arbitrary value
  assign syncIn = {
    modePins,
    chipLockFlag,
    networkLockFlag,
    phyLockFlag,
    eventPending
  };

  // Pins and lock inputs pass two flip-flops
  generate
    for (bitIndex = 0; bitIndex < 8; bitIndex = bitIndex + 1)
    begin : gen_sync
      reg stage1_reg;
      reg stage2_reg;
      always @(posedge core_clk)
      begin
        if (!resetn)
        begin
          stage1_reg <= 1'b0;
          stage2_reg <= 1'b0;
        end
        else
        begin
          stage1_reg <= syncIn[bitIndex];
          stage2_reg <= stage1_reg;
        end
      end
      assign syncOut[bitIndex] = stage2_reg;
    end
  endgenerate

  assign modeSync = syncOut[7:4];
  assign chipLock = syncOut[3];
  assign networkLock = syncOut[2];
  assign phyLock = syncOut[1];
  assign eventSync = syncOut[0];

  // Status byte: lock states, reserved zeros, host mode
  assign parallelHostModeFlag = (modeSync[3:1] == 3'h2); // RQ8
  assign spiHostModeFlag = (modeSync == 4'h0); // RQ9
  assign systemStatus = {
    chipLock,
    networkLock,
    phyLock,
    3'h0,
    parallelHostModeFlag,
    spiHostModeFlag
  }; // RQ2

  // Write gates handed to the locked register groups
  assign netAddrWriteEn = netAddrWriteReq & ~networkLock; // RQ4 RQ5 RQ16
  assign ipv6GatewayWriteEn = ipv6GatewayWriteReq; // RQ6
  assign phyCtrlWriteEn = phyCtrlWriteReq & ~phyLock; // RQ7 RQ16

  // Chip lock refuses both system config registers
  assign softResetWrite = regWrite && (regAddr == `SOFT_RESET_CONTROL_ADDR)
    && !chipLock; // RQ3 RQ11 RQ16
  assign configWrite = regWrite && (regAddr == `IRQ_AND_CLOCK_CONFIG_ADDR)
    && !chipLock; // RQ3 RQ13 RQ16
  // Tick counter cleared by any write to its clear address
  assign tickClear = regWrite && (regAddr == `TICK_COUNTER_CLEAR_ADDR); // RQ15

  // A cleared reset bit holds the rest of the bank in reset for one cycle
  assign softResetRequest = !softReset_reg[`SOFT_RESET_BIT];
  assign localResetN = resetn & ~softResetRequest; // RQ10

  always @*
  begin
    softReset_next = softReset_reg;
    if (softResetRequest)
    begin
      softReset_next = `SOFT_RESET_CONTROL_RESET; // RQ10
    end
    else if (softResetWrite)
    begin
      softReset_next = {regWriteData[`SOFT_RESET_BIT], 7'h00}; // RQ10 RQ11
    end
  end

  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      softReset_reg <= `SOFT_RESET_CONTROL_RESET; // RQ10
    end
    else
    begin
      softReset_reg <= softReset_next;
    end
  end

  // Config: interrupt enable and clock select, reserved bits kept at zero
  always @*
  begin
    config_next = config_reg;
    if (configWrite)
    begin
      config_next = {regWriteData[`IRQ_ENABLE_BIT], 6'h00,
        regWriteData[`SYSCLK_SELECT_BIT]}; // RQ12 RQ13
    end
    irqOut_next = ~(config_reg[`IRQ_ENABLE_BIT] & eventSync); // RQ12
  end

  // Soft reset output is registered: low in the cycle after each cycle the bank is held in reset
  always @(posedge core_clk)
  begin
    if (!localResetN)
    begin
      config_reg <= `IRQ_AND_CLOCK_CONFIG_RESET; // RQ10
      irqOutN <= 1'b1;
      softResetN <= 1'b0; // RQ10
    end
    else
    begin
      config_reg <= config_next;
      irqOutN <= irqOut_next; // RQ12
      softResetN <= 1'b1;
    end
  end

  assign sysclkSelect = config_reg[`SYSCLK_SELECT_BIT]; // RQ13

  tick_timer u_tick_timer (
    .core_clk(core_clk),
    .resetn(localResetN),
    .clear(tickClear),
    .tickCount(tickCounter)
  );

  // Read data registered one cycle after the read strobe, held until the next read or a bank reset clears it to zero
  always @*
  begin
    readData_next = regReadData;
    if (regRead)
    begin
      case (regAddr)
        `VERSION_CODE_HI_ADDR: readData_next = versionCode[15:8]; // RQ1
        `VERSION_CODE_LO_ADDR: readData_next = versionCode[7:0]; // RQ1
        `SYSTEM_STATUS_ADDR: readData_next = systemStatus; // RQ2
        `SOFT_RESET_CONTROL_ADDR: readData_next = 8'h00; // RQ10
        `IRQ_AND_CLOCK_CONFIG_ADDR: readData_next = config_reg; // RQ12 RQ13
        `TICK_COUNTER_HI_ADDR: readData_next = tickCounter[15:8]; // RQ14
        `TICK_COUNTER_LO_ADDR: readData_next = tickCounter[7:0]; // RQ14
        default: readData_next = 8'h00;
      endcase
    end
  end

  always @(posedge core_clk)
  begin
    if (!localResetN)
    begin
      regReadData <= 8'h00;
    end
    else
    begin
      regReadData <= readData_next;
    end
  end
endmodule // system_config_status_regs

// ==== system_config_status_regs_properties.sv ====
// Port-level assertions for the system register bank
`timescale 1ns/1ps
module system_config_status_regs_properties (
  input wire core_clk,
  input wire resetn,
  input wire regWrite,
  input wire chipLockFlag,
  input wire networkLockFlag,
  input wire phyLockFlag,
  input wire eventPending,
  input wire netAddrWriteReq,
  input wire ipv6GatewayWriteReq,
  input wire netAddrWriteEn,
  input wire ipv6GatewayWriteEn,
  input wire phyCtrlWriteEn,
  input wire irqOutN,
  input wire sysclkSelect,
  input wire softResetN,
  input wire [15:0] regAddr,
  input wire [7:0] regWriteData
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence openChip; (!chipLockFlag) [*4]; endsequence
  sequence shutChip; chipLockFlag [*4]; endsequence
  sequence cfgWrite; regWrite && regAddr == 16'h2005; endsequence
  sequence rstWrite; regWrite && regAddr == 16'h2004 && !regWriteData[7]; endsequence
  a_netaddr_gate: assert property (networkLockFlag [*4] |-> !netAddrWriteEn)
    else $error("net write passed while locked");
  a_netaddr_open: assert property ((!networkLockFlag) [*4] ##0 netAddrWriteReq |-> netAddrWriteEn)
    else $error("net write refused while open");
  a_gw_open: assert property (ipv6GatewayWriteEn == ipv6GatewayWriteReq)
    else $error("gateway write gated");
  a_phy_gate: assert property (phyLockFlag [*4] |-> !phyCtrlWriteEn)
    else $error("phy write passed while locked");
  a_irq_quiet: assert property ((!eventPending) [*4] |-> irqOutN)
    else $error("irq low without event");
  a_clk_write: assert property (openChip ##0 cfgWrite |=> sysclkSelect == $past(regWriteData[0]))
    else $error("clock select not written");
  a_clk_locked: assert property (shutChip ##0 cfgWrite |=> $stable(sysclkSelect))
    else $error("clock select changed while locked");
  a_softrst_clears: assert property (openChip ##0 rstWrite |-> ##[1:2] !sysclkSelect)
    else $error("soft reset left config");
  a_softrst_pulse: assert property (openChip ##0 rstWrite |-> ##2 !softResetN)
    else $error("soft reset output not pulsed");
  a_softrst_locked: assert property (shutChip ##0 rstWrite |-> ##2 softResetN)
    else $error("soft reset taken while locked");
endmodule // system_config_status_regs_properties
bind system_config_status_regs system_config_status_regs_properties chk (.*);

// ==== host_model.sv ====
// Host processor model driving the register bus
`timescale 1ns/1ps
module host_model (
  input wire core_clk,
  output reg [15:0] regAddr = 16'h0000,
  output reg regWrite = 1'h0,
  output reg regRead = 1'h0,
  output reg [7:0] regWriteData = 8'h00
);
  task wr(input [15:0] a, input [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWriteData <= d;
    regWrite <= 1'h1;
    @(posedge core_clk);
    regWrite <= 1'h0;
  endtask
  task rd(input [15:0] a);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'h1;
    @(posedge core_clk);
    regRead <= 1'h0;
  endtask
endmodule // host_model

// ==== tb.sv ====
// Self-checking bench for the system register bank
`timescale 1ns/1ps
`include "system_config_status_regs.vh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin bad_count++; $display("mismatch %0t got %h want %h", $time, a, e); end end
module tb;
  reg core_clk = 0, resetn = 0, chipLockFlag = 0, networkLockFlag = 0, phyLockFlag = 0;
  reg eventPending = 0, netAddrWriteReq = 0, ipv6GatewayWriteReq = 0, phyCtrlWriteReq = 0, rdLag = 0;
  reg [3:0] modePins = 4'h0;
  reg [31:0] seed = 32'h00015734;
  reg [15:0] version_code = `VERSION_CODE_VALUE;
  wire [15:0] regAddr;
  wire [7:0] regWriteData, regReadData;
  wire regWrite, regRead, netAddrWriteEn, ipv6GatewayWriteEn, phyCtrlWriteEn, irqOutN;
  wire sysclkSelect, softResetN;
  int bad_count = 0, cmp_count = 0, i;
  reg [7:0] q[$];
  host_model host (.*);
  system_config_status_regs uut (.*);
  function [31:0] xs(input [31:0] s);
    xs = s ^ (s << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
  endfunction
  task conclude;
    if (bad_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task rd(input [15:0] a, input [7:0] e);
    q.push_back(e);
    host.rd(a);
  endtask
  task settle;
    repeat (4) @(posedge core_clk);
  endtask
  initial forever #25 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    if (rdLag)
    begin
      `CHK(regReadData, q[0])
      void'(q.pop_front());
    end
    rdLag <= regRead;
  end
  initial
  begin
    repeat (60000) @(posedge core_clk);
    bad_count++;
    conclude;
  end
  initial
  begin
    repeat (12) @(posedge core_clk);
    resetn <= 1'h1;
    rd(16'h0002, version_code[15:8]);
    rd(16'h0003, version_code[7:0]);
    rd(16'h2017, 8'h00);
    rd(16'h1000, 8'h00);
    rd(16'h2004, 8'h00);
    for (i = 0; i < 16; i++)
    begin
      seed = xs(seed);
      {chipLockFlag, networkLockFlag, phyLockFlag} <= seed[2:0];
      {netAddrWriteReq, ipv6GatewayWriteReq, phyCtrlWriteReq} <= seed[5:3];
      modePins <= i[3:0];
      settle;
      `CHK(netAddrWriteEn, netAddrWriteReq & ~networkLockFlag)
      `CHK(phyCtrlWriteEn, phyCtrlWriteReq & ~phyLockFlag)
      `CHK(ipv6GatewayWriteEn, ipv6GatewayWriteReq)
      rd(16'h2000, {chipLockFlag, networkLockFlag, phyLockFlag, 3'h0, modePins[3:1] == 3'h2,
        modePins == 4'h0});
    end
    chipLockFlag <= 1'h0;
    settle;
    host.wr(16'h2005, 8'h81);
    @(posedge core_clk);
    `CHK(sysclkSelect, 1'h1)
    rd(16'h2005, 8'h81);
    chipLockFlag <= 1'h1;
    settle;
    host.wr(16'h2005, 8'h00);
    host.wr(16'h2004, 8'h00);
    settle;
    `CHK(sysclkSelect, 1'h1)
    chipLockFlag <= 1'h0;
    eventPending <= 1'h1;
    settle;
    `CHK(irqOutN, 1'h0)
    host.wr(16'h2005, 8'h01);
    settle;
    `CHK(irqOutN, 1'h1)
    host.wr(16'h2004, 8'h00);
    repeat (2) @(posedge core_clk);
    `CHK(softResetN, 1'h0)
    settle;
    `CHK({sysclkSelect, irqOutN}, 2'h0)
    host.wr(16'h2020, 8'h00);
    repeat (`TICK_CYCLES + 4) @(posedge core_clk);
    rd(16'h2016, 8'h00);
    rd(16'h2017, 8'h01);
    host.wr(16'h2020, 8'h5a);
    rd(16'h2017, 8'h00);
    settle;
    conclude;
  end
endmodule // tb
